// *** adc_ctl_defines.svh ***
// Named constants of the converter control block.
`ifndef ADC_CTL_DEFINES_SVH
`define ADC_CTL_DEFINES_SVH

// ****************************************
// Widths
// ****************************************
`define RESULT_W 12
`define RESULT_MSB 11
`define CNT_W 11
`define BIT_CNT_W 4
`define SYNC_W 3

// ****************************************
// Pin positions inside the synchroniser
// ****************************************
`define PIN_CST 0
`define PIN_CS 1
`define PIN_SCLK 2

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS 50
`define CONV_TIME_NS 650
`define PWRUP_TIME_US 100
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PWRUP_CYCLES ((`PWRUP_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_LOAD (`CNT_W'(`CONV_CYCLES - 1))
`define PWRUP_LOAD (`CNT_W'(`PWRUP_CYCLES - 1))
`define CNT_ZERO 11'h000

// ****************************************
// Serial frame
// ****************************************
`define LAST_BIT_CNT 4'hc
`define FIRST_BIT_CNT 4'h1
`define BIT_CNT_ZERO 4'h0
`define RESULT_ZERO 12'h000

`endif

// *** adc_ctl_pkg.sv ***
// Types shared by the converter control block.
`include "adc_ctl_defines.svh"

package adc_ctl_pkg;

	typedef enum logic [1:0] {
		ST_TRACK = 2'b00,
		ST_CONVERT = 2'b01,
		ST_POWER_DOWN = 2'b10,
		ST_WAKE = 2'b11
	} ctl_state_type;

	typedef struct packed {
		logic sclk;
		logic frame_select_n;
		logic conversion_start_n;
	} pins_type;

	typedef struct packed {
		ctl_state_type st;
		logic [`CNT_W-1:0] cnt;
		logic [`RESULT_W-1:0] result;
		logic cst_prev;
		logic cs_prev;
		logic sclk_prev;
		logic busy_en;
		logic busy_go;
		logic switch_closed;
		logic analog_on;
	} ctl_regs_type;

	typedef struct packed {
		logic [`RESULT_W-1:0] shreg;
		logic [`BIT_CNT_W-1:0] cnt;
		logic data;
		logic drive;
	} shift_regs_type;

endpackage : adc_ctl_pkg

// *** pin_sync.sv ***
// Two-stage synchronisers for the host pins.
`timescale 1ns/1ps

module pin_sync (
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic clk_en_in,
	input wire adc_ctl_pkg::pins_type pins_in,
	output adc_ctl_pkg::pins_type pins_out
);
	import adc_ctl_pkg::*;

	logic [`SYNC_W-1:0] raw;
	logic [`SYNC_W-1:0] stable;

	assign raw = pins_in;
	assign pins_out = stable;

	// Reset level is high on every pin, so no false start or select edge follows reset; sclk rests low and can show one false fall.
	for (genvar i = 0; i < `SYNC_W; i++) begin : g_bit
		typedef struct packed {
			logic s1;
			logic s2;
		} sync_regs_type;
		sync_regs_type regs_q;
		sync_regs_type regs_d;

		always_comb begin
			regs_d.s1 = raw[i];
			regs_d.s2 = regs_q.s1;
		end

		always_ff @(posedge mclk_in) begin
			if (sys_rst_in) begin
				regs_q <= '1;
			end else if (clk_en_in) begin
				regs_q <= regs_d;
			end
		end

		assign stable[i] = regs_q.s2;
	end

endmodule : pin_sync

// *** result_shifter.sv ***
// Twelve-bit output shift register driving the serial result pin.
`timescale 1ns/1ps

module result_shifter (
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic clk_en_in,
	input wire logic [`RESULT_W-1:0] result_in,
	input wire logic busy_start_in,
	input wire logic frame_open_in,
	input wire logic frame_close_in,
	input wire logic shift_in,
	output logic serial_result_out,
	output logic serial_result_oe_n_out
);
	import adc_ctl_pkg::*;

	shift_regs_type regs_q;
	shift_regs_type regs_d;

	always_comb begin
		regs_d = regs_q;
		if (frame_close_in) begin
			regs_d.drive = 1'b0;
		end else if (busy_start_in) begin
			regs_d.drive = 1'b1;
			regs_d.data = 1'b0;
			regs_d.shreg = result_in;
			regs_d.cnt = `BIT_CNT_ZERO;
		end else if (frame_open_in) begin
			regs_d.drive = 1'b1;
			regs_d.data = result_in[`RESULT_MSB];
			regs_d.shreg = {result_in[`RESULT_MSB-1:0], 1'b0};
			regs_d.cnt = `FIRST_BIT_CNT;
		end else if (shift_in && regs_q.drive) begin
			// The edge after the last bit releases the pin.
			if (regs_q.cnt == `LAST_BIT_CNT) begin
				regs_d.drive = 1'b0;
			end else begin
				regs_d.data = regs_q.shreg[`RESULT_MSB];
				regs_d.shreg = {regs_q.shreg[`RESULT_MSB-1:0], 1'b0};
				regs_d.cnt = regs_q.cnt + `FIRST_BIT_CNT;
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			regs_q <= '0;
		end else if (clk_en_in) begin
			regs_q <= regs_d;
		end
	end

	assign serial_result_out = regs_q.data;
	assign serial_result_oe_n_out = !regs_q.drive;

endmodule : result_shifter

// *** sar_adc_ctl.sv ***
// Conversion timing, power mode and serial readout control of a 12-bit converter.
`timescale 1ns/1ps

module sar_adc_ctl (
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic clk_en_in,
	input wire logic conversion_start_n_in,
	input wire logic frame_select_n_in,
	input wire logic serial_clk_in,
	input wire logic [`RESULT_W-1:0] analog_code_in,
	output logic serial_result_out,
	output logic serial_result_oe_n_out,
	output logic sample_switch_closed_out,
	output logic analog_power_on_out,
	output logic converting_out,
	output logic powering_up_out,
	output logic power_down_out
);
	import adc_ctl_pkg::*;

	// ****************************************
	// Pin synchronisation and edges
	// ****************************************
	pins_type pins_raw;
	pins_type pins_sync;
	ctl_regs_type regs_q;
	ctl_regs_type regs_d;
	logic cst_fall;
	logic cst_rise;
	logic cs_fall;
	logic cs_rise;
	logic sclk_fall;
	logic eoc;
	logic wake_done;

	assign pins_raw.conversion_start_n = conversion_start_n_in;
	assign pins_raw.frame_select_n = frame_select_n_in;
	assign pins_raw.sclk = serial_clk_in;

	pin_sync u_sync (
		.mclk_in(mclk_in),
		.sys_rst_in(sys_rst_in),
		.clk_en_in(clk_en_in),
		.pins_in(pins_raw),
		.pins_out(pins_sync)
	);

	assign cst_fall = regs_q.cst_prev && !pins_sync.conversion_start_n;
	assign cst_rise = !regs_q.cst_prev && pins_sync.conversion_start_n;
	assign cs_fall = regs_q.cs_prev && !pins_sync.frame_select_n;
	assign cs_rise = !regs_q.cs_prev && pins_sync.frame_select_n;
	assign sclk_fall = regs_q.sclk_prev && !pins_sync.sclk;
	assign eoc = (regs_q.st == ST_CONVERT) && (regs_q.cnt == `CNT_ZERO);
	assign wake_done = (regs_q.st == ST_WAKE) && (regs_q.cnt == `CNT_ZERO);

	// ****************************************
	// Conversion and power mode control
	// ****************************************
	always_comb begin
		regs_d = regs_q;
		regs_d.cst_prev = pins_sync.conversion_start_n;
		regs_d.cs_prev = pins_sync.frame_select_n;
		regs_d.sclk_prev = pins_sync.sclk;
		regs_d.busy_go = 1'b0;
		unique case (regs_q.st)
			ST_TRACK: begin
				if (cst_fall) begin
					regs_d.st = ST_CONVERT;
					regs_d.cnt = `CONV_LOAD;
					regs_d.switch_closed = 1'b0;
				end
			end
			ST_CONVERT: begin
				// Further start edges fall through here unseen.
				if (eoc) begin
					regs_d.result = analog_code_in;
					regs_d.switch_closed = 1'b1;
					regs_d.busy_en = !pins_sync.frame_select_n;
					regs_d.busy_go = regs_q.busy_en && !pins_sync.frame_select_n;
					if (pins_sync.conversion_start_n) begin
						regs_d.st = ST_TRACK;
					end else begin
						regs_d.st = ST_POWER_DOWN;
						regs_d.analog_on = 1'b0;
					end
				end else begin
					regs_d.cnt = regs_q.cnt - `CNT_W'(1);
				end
			end
			ST_POWER_DOWN: begin
				// A start pin left low keeps the part down; only a rise wakes it.
				if (cst_rise) begin
					regs_d.st = ST_WAKE;
					regs_d.cnt = `PWRUP_LOAD;
					regs_d.analog_on = 1'b1;
				end
			end
			ST_WAKE: begin
				if (wake_done) begin
					regs_d.st = ST_TRACK;
				end else begin
					regs_d.cnt = regs_q.cnt - `CNT_W'(1);
				end
			end
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			regs_q.st <= ST_TRACK;
			regs_q.cnt <= `CNT_ZERO;
			regs_q.result <= `RESULT_ZERO;
			regs_q.cst_prev <= 1'b1;
			regs_q.cs_prev <= 1'b1;
			regs_q.sclk_prev <= 1'b0;
			regs_q.busy_en <= 1'b0;
			regs_q.busy_go <= 1'b0;
			regs_q.switch_closed <= 1'b1;
			regs_q.analog_on <= 1'b1;
		end else if (clk_en_in) begin
			regs_q <= regs_d;
		end
	end

	assign sample_switch_closed_out = regs_q.switch_closed;
	assign analog_power_on_out = regs_q.analog_on;
	assign converting_out = (regs_q.st == ST_CONVERT);
	assign powering_up_out = (regs_q.st == ST_WAKE);
	assign power_down_out = (regs_q.st == ST_POWER_DOWN);

	// ****************************************
	// Serial readout
	// ****************************************
	logic frame_open;

	// A frame opened mid-conversion would show a stale word, so a select fall during a conversion opens no frame.
	assign frame_open = cs_fall && (regs_q.st != ST_CONVERT);

	result_shifter u_shift (
		.mclk_in(mclk_in),
		.sys_rst_in(sys_rst_in),
		.clk_en_in(clk_en_in),
		.result_in(regs_q.result),
		.busy_start_in(regs_q.busy_go),
		.frame_open_in(frame_open),
		.frame_close_in(cs_rise),
		.shift_in(sclk_fall),
		.serial_result_out(serial_result_out),
		.serial_result_oe_n_out(serial_result_oe_n_out)
	);

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (sys_rst_in || !clk_en_in);

	logic [`BIT_CNT_W-1:0] sclk_seen;
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in || cs_fall || regs_q.busy_go) begin
			sclk_seen <= `BIT_CNT_ZERO;
		end else if (clk_en_in && sclk_fall && sclk_seen != 4'hf) begin
			sclk_seen <= sclk_seen + 4'h1;
		end
	end

	a_start_edge: assert property ((regs_q.st == ST_TRACK) && cst_fall
		|=> converting_out && !sample_switch_closed_out)
		else $error("start edge did not begin a conversion");

	a_conv_length: assert property ($rose(converting_out)
		|-> converting_out [*8] ##1 (converting_out [*5]) ##1 !converting_out)
		else $error("conversion did not last thirteen cycles");

	a_mode_normal: assert property (eoc && pins_sync.conversion_start_n
		|=> (regs_q.st == ST_TRACK) && analog_power_on_out)
		else $error("high start level at end of conversion left normal mode");

	a_mode_down: assert property (eoc && !pins_sync.conversion_start_n
		|=> power_down_out && !analog_power_on_out)
		else $error("low start level at end of conversion did not power down");

	a_wake_edge: assert property (power_down_out && cst_rise
		|=> powering_up_out && analog_power_on_out && regs_q.cnt == `PWRUP_LOAD)
		else $error("rising start edge did not begin power-up");

	a_stay_down: assert property (power_down_out && !cst_rise |=> power_down_out)
		else $error("left power-down without a rising start edge");

	a_wake_hold: assert property (powering_up_out && regs_q.cnt != `CNT_ZERO
		|=> powering_up_out && regs_q.cnt == $past(regs_q.cnt) - `CNT_W'(1))
		else $error("power-up ended early or stalled");

	a_wake_end: assert property (wake_done |=> (regs_q.st == ST_TRACK))
		else $error("power-up did not return to tracking");

	a_switch_phase: assert property (converting_out |-> !sample_switch_closed_out)
		else $error("sampling switch closed during conversion");

	a_result_kept: assert property (eoc |=> regs_q.result == $past(analog_code_in)
		##1 (regs_q.result == $past(regs_q.result)) [*3])
		else $error("stored result was not captured or not held");

	a_msb_first: assert property (frame_open && !regs_q.busy_go
		|=> !serial_result_oe_n_out && serial_result_out == regs_q.result[`RESULT_MSB])
		else $error("frame opening did not present the most significant bit");

	a_frame_close: assert property (cs_rise |=> serial_result_oe_n_out)
		else $error("frame select rise did not release the data pin");

	a_busy_low: assert property (regs_q.busy_go && !cs_rise
		|=> !serial_result_oe_n_out && !serial_result_out)
		else $error("busy indication did not drive the data pin low");

	a_bit_count: assert property (sclk_seen > 4'hc |-> serial_result_oe_n_out)
		else $error("data pin driven past the end of the word");

	c_normal_conv: cover property ($rose(converting_out) ##[13:14] (regs_q.st == ST_TRACK));
	c_power_down: cover property (eoc && !pins_sync.conversion_start_n);
	c_wake_done: cover property (wake_done);
	c_busy_frame: cover property (regs_q.busy_go ##[1:1000] $rose(serial_result_oe_n_out));

endmodule : sar_adc_ctl

// *** host_model.sv ***
// Host controller model driving the start, select and serial clock pins.
`timescale 1ns/1ps

module host_model (
	input wire logic mclk_in,
	input wire logic sdo_in,
	output logic conversion_start_n_out,
	output logic frame_select_n_out,
	output logic serial_clk_out
);
	// ****************************************
	// Pin drivers
	// ****************************************
	initial begin
		conversion_start_n_out = 1'b1;
		frame_select_n_out = 1'b1;
		serial_clk_out = 1'b0;
	end

	task automatic idle(input int n);
		repeat (n) @(negedge mclk_in);
	endtask : idle

	// Start pulse; the pin stays low only when power-down is wanted.
	task automatic convert(input logic stay_low);
		idle(8);
		conversion_start_n_out = 1'b0;
		idle(4);
		conversion_start_n_out = !stay_low;
	endtask : convert

	task automatic set_start(input logic v);
		@(negedge mclk_in);
		conversion_start_n_out = v;
	endtask : set_start

	task automatic set_cs(input logic v);
		@(negedge mclk_in);
		frame_select_n_out = v;
	endtask : set_cs

	// The serial clock rests low outside frames so the first bit is not lost.
	// Bits are taken just before each falling edge, a full half period after the update.
	task automatic clock_bits(input int n, output logic [12:0] bits);
		bits = 13'h0000;
		idle(8);
		for (int i = 0; i < n; i++) begin
			serial_clk_out = 1'b1;
			idle(4);
			bits = {bits[11:0], sdo_in};
			serial_clk_out = 1'b0;
			idle(4);
		end
	endtask : clock_bits
endmodule : host_model

// *** sar_adc_conversion_power_control_test.sv ***
// Self-checking bench of the converter control block.
`timescale 1ns/1ps
`include "adc_ctl_defines.svh"

module sar_adc_conversion_power_control_test;
	logic mclk;
	logic rst;
	logic clk_en;
	logic [11:0] code;
	wire cst_n;
	wire cs_n;
	wire sclk;
	wire sdo_wire;
	logic sdo_data;
	logic sdo_oe_n;
	logic sw_closed;
	logic ana_on;
	logic converting;
	logic powering_up;
	logic power_down;
	logic [3:0] flags;
	logic [12:0] bits;
	int n;
	int err_count;
	int samples_checked;

	// The data line carries a pull-up, so a released pin reads high.
	assign sdo_wire = sdo_oe_n ? 1'b1 : sdo_data;
	assign flags = {sdo_oe_n, power_down, powering_up, converting};

	sar_adc_ctl dut (
		.mclk_in(mclk), .sys_rst_in(rst), .clk_en_in(clk_en),
		.conversion_start_n_in(cst_n), .frame_select_n_in(cs_n), .serial_clk_in(sclk),
		.analog_code_in(code), .serial_result_out(sdo_data),
		.serial_result_oe_n_out(sdo_oe_n), .sample_switch_closed_out(sw_closed),
		.analog_power_on_out(ana_on), .converting_out(converting),
		.powering_up_out(powering_up), .power_down_out(power_down)
	);

	host_model host (
		.mclk_in(mclk), .sdo_in(sdo_wire), .conversion_start_n_out(cst_n),
		.frame_select_n_out(cs_n), .serial_clk_out(sclk)
	);

	always #25 mclk = ~mclk;

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic report_and_stop();
		$display("checks=%0d mismatches=%0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : report_and_stop

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	// Counts cycles until a status flag reaches a level; a spent bound ends the run.
	task automatic wait_flag(input int idx, input logic lvl, input int max, output int cnt);
		cnt = 0;
		while (flags[idx] !== lvl) begin
			if (cnt >= max) begin
				err_count++;
				$display("[FAIL] t=%0t got=%h exp=%h", $time, flags[idx], lvl);
				report_and_stop();
			end
			@(negedge mclk);
			cnt++;
		end
	endtask : wait_flag

	task automatic conv_measure(input logic stay_low);
		fork
			host.convert(stay_low);
			begin
				wait_flag(0, 1'b1, 20, n);
				check(sw_closed, 1'b0);
				wait_flag(0, 1'b0, 30, n);
				check(16'(n), 16'h000d);
			end
		join
	endtask : conv_measure

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_short_frame();
		conv_measure(1'b0);
		host.set_cs(1'b0);
		host.clock_bits(4, bits);
		host.set_cs(1'b1);
		host.idle(5);
		check(sdo_oe_n, 1'b1);
	endtask : t_short_frame

	task automatic t_normal(input logic [11:0] v);
		code = v;
		fork
			conv_measure(1'b0);
			begin
				host.idle(16);
				host.set_start(1'b0);
				host.idle(3);
				host.set_start(1'b1);
			end
		join
		check({sw_closed, power_down, ana_on}, 3'h5);
		host.idle(10);
		check(converting, 1'b0);
		host.set_cs(1'b0);
		host.clock_bits(12, bits);
		check(bits, {1'b0, v});
		check(sdo_oe_n, 1'b1);
		host.set_cs(1'b1);
	endtask : t_normal

	task automatic t_power_down();
		code = 12'h5c3;
		conv_measure(1'b1);
		host.idle(20);
		check({power_down, ana_on}, 2'h2);
		code = 12'h0ff;
		host.set_cs(1'b0);
		host.clock_bits(12, bits);
		check(bits, 13'h05c3);
		host.set_cs(1'b1);
		host.set_start(1'b1);
		wait_flag(1, 1'b1, 8, n);
		check({powering_up, ana_on}, 2'h3);
		fork
			wait_flag(1, 1'b0, 2100, n);
			begin
				host.idle(20);
				host.set_start(1'b0);
				host.idle(4);
				host.set_start(1'b1);
			end
		join
		check(16'(n), 16'h07d0);
		host.idle(4);
		check({converting, power_down}, 2'h0);
	endtask : t_power_down

	task automatic t_busy();
		code = 12'h96a;
		fork
			host.convert(1'b0);
			begin
				wait_flag(0, 1'b1, 20, n);
				host.set_cs(1'b0);
				wait_flag(0, 1'b0, 30, n);
			end
		join
		host.idle(6);
		check(sdo_oe_n, 1'b1);
		conv_measure(1'b0);
		wait_flag(3, 1'b0, 6, n);
		host.clock_bits(13, bits);
		check(bits, 13'h096a);
		check(sdo_oe_n, 1'b1);
		host.set_cs(1'b1);
	endtask : t_busy

	// A frozen clock enable must stretch a conversion without losing cycles.
	task automatic t_freeze();
		code = 12'h3c3;
		fork
			host.convert(1'b0);
			begin
				wait_flag(0, 1'b1, 20, n);
				clk_en = 1'b0;
				host.idle(20);
				check({converting, sw_closed}, 2'h2);
				clk_en = 1'b1;
				wait_flag(0, 1'b0, 30, n);
				check(16'(n), 16'h000d);
			end
		join
	endtask : t_freeze

	initial begin
		mclk = 1'b0;
		rst = 1'b1;
		clk_en = 1'b1;
		code = 12'h000;
		err_count = 0;
		samples_checked = 0;
		repeat (4) @(negedge mclk);
		check({sdo_oe_n, sw_closed, ana_on, flags[2:0]}, 6'h38);
		rst = 1'b0;
		t_short_frame();
		t_normal(12'h801);
		t_normal(12'h7fe);
		t_power_down();
		t_normal(12'ha5c);
		t_busy();
		t_freeze();
		report_and_stop();
	end
endmodule : sar_adc_conversion_power_control_test
